// >>> hw/sbsr_consts.svh
`ifndef SBSR_CONSTS_SVH
`define SBSR_CONSTS_SVH

// Status byte bit positions
`define SBSR_BIT_CHAN       3'd2
`define SBSR_BIT_QEVT       3'd3
`define SBSR_BIT_MAV        3'd4
`define SBSR_BIT_ESB        3'd5
`define SBSR_BIT_RQS        3'd6

// Bits that never feed the master summary (bit 6 itself)
`define SBSR_MSS_EXCL_MASK  8'h40
// Bits 0, 1 and 7 have no source and read as zero
`define SBSR_DEFINED_MASK   8'h7c

// Reset values
`define SBSR_SRE_RESET      8'h00
`define SBSR_ESE_RESET      8'h00
`define SBSR_ESR_RESET      8'h00
`define SBSR_BYTE_RESET     8'h00

`endif

// >>> hw/sbsr_pkg.sv
`default_nettype none

package sbsr_pkg;

    // One command from the instrument's command parser
    typedef struct packed {
        logic       serial_poll;
        logic       byte_query;
        logic       clear_status;
        logic       sre_write;
        logic       ese_write;
        logic       esr_read;
        logic [7:0] wdata;
    } sbsr_cmd_t;

    // One answer towards the controller
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sbsr_answer_t;

endpackage

`default_nettype wire

// >>> hw/sbsr_std_event.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbsr_consts.svh"

module sbsr_std_event (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    // Event sources and commands
    input  wire logic [7:0] event_set_i,
    input  wire logic       ese_write_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       esr_read_i,
    input  wire logic       clear_status_i,
    // State
    output logic      [7:0] esr_o,
    output logic      [7:0] ese_o,
    output logic            esb_o
);

    logic [7:0] next_esr;
    logic [7:0] next_ese;

    // Next event and enable values; a new event beats a clear in the same cycle
    always_comb begin
        next_esr = esr_o;
        next_ese = ese_o;
        if (esr_read_i || clear_status_i) begin
            next_esr = `SBSR_ESR_RESET;
        end
        next_esr = next_esr | event_set_i;
        if (ese_write_i) begin
            next_ese = wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            esr_o <= `SBSR_ESR_RESET;
            ese_o <= `SBSR_ESE_RESET;
        end else begin
            esr_o <= next_esr;
            ese_o <= next_ese;
        end
    end

    assign esb_o = |(esr_o & ese_o);

    a_esr_read_clear : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (esr_read_i && event_set_i == 8'h00) |=> esr_o == 8'h00)
        else $error("event register not cleared by read");

    // no enabled event means no summary
    a_esb_masked : assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (((esr_o & ese_o) == 8'h00) && ((event_set_i & ese_o) == 8'h00) && !ese_write_i)
        |=> !esb_o)
        else $error("summary set without enabled event");

endmodule
`default_nettype wire

// >>> hw/sbsr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbsr_consts.svh"

// Operation
// - The status byte summarizes the events held in all lower-level status registers.
// - The controller reads the byte by serial poll or by status query; a poll wins over a query in the same cycle.
// - A serial poll returns the request bit and then clears it, leaving other bits alone.
// - Bit 6 carries the request bit on a poll and the master summary on a query.
// - A query shows the master summary in bit 6 and changes no bit of the byte.
// - The master summary is set while any enabled condition calls for service.
// - The clear-status command clears the request bit and the standard event register.
// - Bit 2 shows that an enabled channel event has occurred.
// - Bit 3 shows that an enabled questionable event has occurred.
// - Bit 4 is set while the output queue holds unread data.
// - Bit 5 shows that an enabled standard event has occurred.
// - The controller writes the request enable mask and only masked bits raise requests.
// - The standard event summary is the OR of enabled standard event bits.
// - Reading the standard event register returns it and then zeroes it.

module sbsr_top (
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // Commands from the parser
    input  var  sbsr_pkg::sbsr_cmd_t  cmd_i,
    // Summaries from lower-level registers
    input  wire logic                 chan_summary_i,
    input  wire logic                 questionable_event_summary_i,
    input  wire logic                 queue_not_empty_i,
    input  wire logic [7:0]           std_event_set_i,
    // Answers and request
    output sbsr_pkg::sbsr_answer_t    byte_answer_o,
    output sbsr_pkg::sbsr_answer_t    esr_answer_o,
    output logic                      srq_o,
    output logic      [7:0]           sre_o
);

    logic [7:0]             esr;
    logic [7:0]             ese;
    logic                   esb;
    logic [7:0]             summary;
    logic                   mss;
    logic                   mss_prev;
    logic                   mss_rise;
    logic                   rqs;
    logic                   next_rqs;
    logic                   next_mss_prev;
    logic [7:0]             sre;
    logic [7:0]             next_sre;
    sbsr_pkg::sbsr_answer_t next_byte_answer;
    sbsr_pkg::sbsr_answer_t next_esr_answer;

    // Builds the reported byte with the chosen bit 6 value
    function automatic logic [7:0] byte_with_bit6(input logic [7:0] sum, input logic b6);
        logic [7:0] v;
        v = sum & ~`SBSR_MSS_EXCL_MASK;
        v[`SBSR_BIT_RQS] = b6;
        return v;
    endfunction

    // Standard event register and its enable mask
    sbsr_std_event u_std_event (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .event_set_i    (std_event_set_i),
        .ese_write_i    (cmd_i.ese_write),
        .wdata_i        (cmd_i.wdata),
        .esr_read_i     (cmd_i.esr_read),
        .clear_status_i (cmd_i.clear_status),
        .esr_o          (esr),
        .ese_o          (ese),
        .esb_o          (esb)
    );

    // Live summary byte; bits 0, 1 and 7 have no source
    always_comb begin
        summary = `SBSR_BYTE_RESET;
        summary[`SBSR_BIT_CHAN] = chan_summary_i;
        summary[`SBSR_BIT_QEVT] = questionable_event_summary_i;
        summary[`SBSR_BIT_MAV]  = queue_not_empty_i;
        summary[`SBSR_BIT_ESB]  = esb;
        summary = summary & `SBSR_DEFINED_MASK;
    end

    assign mss      = |(summary & sre & ~`SBSR_MSS_EXCL_MASK);
    assign mss_rise = mss && !mss_prev;

    // Request bit, summary history and enable mask
    always_comb begin
        next_sre      = sre;
        next_rqs      = rqs;
        next_mss_prev = mss;
        if (cmd_i.sre_write) begin
            next_sre = cmd_i.wdata;
        end
        if (cmd_i.serial_poll || cmd_i.clear_status) begin
            next_rqs = 1'b0;
        end
        // rising summary sets request, wins over clear
        if (mss_rise) begin
            next_rqs = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sre      <= `SBSR_SRE_RESET;
            rqs      <= 1'b0;
            mss_prev <= 1'b0;
        end else begin
            sre      <= next_sre;
            rqs      <= next_rqs;
            mss_prev <= next_mss_prev;
        end
    end

    // Answers; a poll beats a query in the same cycle
    always_comb begin
        next_byte_answer.valid = 1'b0;
        next_byte_answer.data  = byte_answer_o.data;
        next_esr_answer.valid  = cmd_i.esr_read;
        next_esr_answer.data   = esr_answer_o.data;
        if (cmd_i.serial_poll) begin
            next_byte_answer.valid = 1'b1;
            next_byte_answer.data  = byte_with_bit6(summary, rqs);
        end else if (cmd_i.byte_query) begin
            next_byte_answer.valid = 1'b1;
            next_byte_answer.data  = byte_with_bit6(summary, mss);
        end
        if (cmd_i.esr_read) begin
            next_esr_answer.data = esr;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            byte_answer_o <= '0;
            esr_answer_o  <= '0;
        end else begin
            byte_answer_o <= next_byte_answer;
            esr_answer_o <= next_esr_answer;
        end
    end

    // Request line follows the sticky request bit
    assign srq_o = rqs;
    assign sre_o = sre;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_poll_clears_rqs : assert property (
        (cmd_i.serial_poll && !mss_rise) |=> !srq_o)
        else $error("request bit survived serial poll");

    a_poll_reports_rqs : assert property (
        cmd_i.serial_poll |=> byte_answer_o.valid && byte_answer_o.data[6] == $past(rqs))
        else $error("poll answer bit 6 is not the request bit");

    a_query_reports_mss : assert property (
        (cmd_i.byte_query && !cmd_i.serial_poll && !cmd_i.clear_status)
        |=> byte_answer_o.data[6] == $past(mss) && srq_o == ($past(rqs) || $past(mss_rise)))
        else $error("query answer wrong or byte disturbed");

    a_cls_clears_rqs : assert property (
        (cmd_i.clear_status && !mss_rise) |=> !srq_o)
        else $error("request bit survived clear-status");

    a_chan_bit : assert property (
        cmd_i.serial_poll |=> byte_answer_o.data[2] == $past(chan_summary_i))
        else $error("channel summary bit wrong");

    a_qevt_bit : assert property (
        cmd_i.byte_query |=> byte_answer_o.data[3] == $past(questionable_event_summary_i))
        else $error("questionable summary bit wrong");

    a_mav_bit : assert property (
        cmd_i.serial_poll |=> byte_answer_o.data[4] == $past(queue_not_empty_i))
        else $error("message available bit wrong");

    a_esb_bit : assert property (
        cmd_i.serial_poll |=> byte_answer_o.data[5] == $past(|(esr & ese)))
        else $error("standard event summary bit wrong");

    a_mask_gates_mss : assert property (
        (sre_o == 8'h00 && !cmd_i.sre_write && !srq_o) |=> !srq_o)
        else $error("request raised with empty enable mask");

    a_enabled_mss : assert property (
        (questionable_event_summary_i && sre[3]) |-> mss)
        else $error("enabled condition without master summary");

    // rising summary raises request, still set two cycles later
    a_rqs_on_rise : assert property (
        (mss_rise ##1 (!cmd_i.serial_poll && !cmd_i.clear_status)) |=> srq_o [*1])
        else $error("request not raised on rising summary");

    // Main scenarios
    c_poll_with_rqs : cover property (cmd_i.serial_poll && rqs);
    c_query_with_mss : cover property (cmd_i.byte_query && mss);
    c_rise_on_clear : cover property (mss_rise && cmd_i.clear_status);
    c_esr_read : cover property (cmd_i.esr_read && esr != 8'h00);

endmodule
`default_nettype wire

// >>> verif/sbsr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sbsr_ctrl_model (
    // Clock
    input  wire logic                    clk_sys_i,
    // Commands towards the block
    output var  sbsr_pkg::sbsr_cmd_t     cmd_o,
    // Answers from the block
    input  var  sbsr_pkg::sbsr_answer_t  byte_answer_i,
    input  var  sbsr_pkg::sbsr_answer_t  esr_answer_i
);
    // Answer seen after the latest command
    sbsr_pkg::sbsr_answer_t last;

    // Idle: no strobes, data low
    initial begin
        cmd_o = '0;
        last  = '0;
    end

    // poll, query, clear, mask and enable writes, event read
    // One-cycle strobe from a falling edge; the answer stands right after
    // the taking edge, so it is captured at the next falling edge, half a cycle later.
    task automatic issue(input logic [5:0] fields, input logic [7:0] data);
        @(negedge clk_sys_i);
        cmd_o = {fields, data};
        @(negedge clk_sys_i);
        cmd_o = '0;
        last  = fields[0] ? esr_answer_i : byte_answer_i;
    endtask
endmodule

`default_nettype wire

// >>> verif/sbsr_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sbsr_bench;
    // Command strobe encodings, poll down to event read
    localparam logic [5:0] op_poll  = 6'h20;
    localparam logic [5:0] op_query = 6'h10;
    localparam logic [5:0] op_clear = 6'h08;
    localparam logic [5:0] op_sre   = 6'h04;
    localparam logic [5:0] op_ese   = 6'h02;
    localparam logic [5:0] op_esr   = 6'h01;

    // Stimulus and observation
    logic                   clk_sys_i = 1'b0;
    logic                   rst_i     = 1'b1;
    logic                   chan      = 1'b0;
    logic                   qevt      = 1'b0;
    logic                   mav       = 1'b0;
    logic [7:0]             std_ev    = 8'h00;
    sbsr_pkg::sbsr_cmd_t    cmd;
    sbsr_pkg::sbsr_answer_t byte_ans;
    sbsr_pkg::sbsr_answer_t esr_ans;
    logic                   srq;
    logic [7:0]             sre;
    int                     n_fail    = 0;
    int                     cmp_count = 0;

    // 40 MHz clock
    always #12.5 clk_sys_i = ~clk_sys_i;

    sbsr_top dut (
        .clk_sys_i                    (clk_sys_i),
        .rst_i                        (rst_i),
        .cmd_i                        (cmd),
        .chan_summary_i               (chan),
        .questionable_event_summary_i (qevt),
        .queue_not_empty_i            (mav),
        .std_event_set_i              (std_ev),
        .byte_answer_o                (byte_ans),
        .esr_answer_o                 (esr_ans),
        .srq_o                        (srq),
        .sre_o                        (sre)
    );

    sbsr_ctrl_model ctrl (
        .clk_sys_i     (clk_sys_i),
        .cmd_o         (cmd),
        .byte_answer_i (byte_ans),
        .esr_answer_i  (esr_ans)
    );

    // Byte compare, unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Answer compare: valid pulse present and byte as expected
    task automatic chk_ans(input logic [7:0] exp);
        chk({7'h00, ctrl.last.valid}, 8'h01);
        chk(ctrl.last.data, exp);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Message available raises a request; query keeps it, poll drops it
    task automatic t_mav_request();
        ctrl.issue(op_sre, 8'h10);
        chk(sre, 8'h10);
        @(negedge clk_sys_i);
        mav = 1'b1;
        @(negedge clk_sys_i);
        chk({7'h00, srq}, 8'h01);
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h50);
        chk({7'h00, srq}, 8'h01);
        ctrl.issue(op_poll, 8'h00);
        chk_ans(8'h50);
        chk({7'h00, srq}, 8'h00);
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h50);
        @(negedge clk_sys_i);
        mav = 1'b0;
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h00);
    endtask

    // Masked-out summaries stay silent until the mask selects them
    task automatic t_mask();
        @(negedge clk_sys_i);
        chan = 1'b1;
        qevt = 1'b1;
        @(negedge clk_sys_i);
        chk({7'h00, srq}, 8'h00);
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h0c);
        ctrl.issue(op_sre, 8'h04);
        @(negedge clk_sys_i);
        chk({7'h00, srq}, 8'h01);
        chan = 1'b0;
        ctrl.issue(op_poll, 8'h00);
        chk_ans(8'h48);
        qevt = 1'b0;
    endtask

    // Standard events summarised through the enable, cleared by reading
    task automatic t_std_event();
        ctrl.issue(op_ese, 8'h20);
        std_ev = 8'h24;
        @(negedge clk_sys_i);
        std_ev = 8'h00;
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h20);
        ctrl.issue(op_esr, 8'h00);
        chk_ans(8'h24);
        ctrl.issue(op_esr, 8'h00);
        chk_ans(8'h00);
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h00);
    endtask

    // Clear-status drops the request bit and the event summary
    task automatic t_clear();
        ctrl.issue(op_sre, 8'h20);
        std_ev = 8'h20;
        @(negedge clk_sys_i);
        std_ev = 8'h00;
        @(negedge clk_sys_i);
        chk({7'h00, srq}, 8'h01);
        ctrl.issue(op_clear, 8'h00);
        chk({7'h00, srq}, 8'h00);
        ctrl.issue(op_query, 8'h00);
        chk_ans(8'h00);
    endtask

    // Reset, then each scenario in turn
    initial begin
        repeat (5) @(negedge clk_sys_i);
        rst_i = 1'b0;
        chk(sre, 8'h00);
        chk({7'h00, srq}, 8'h00);
        t_mav_request();
        t_mask();
        t_std_event();
        t_clear();
        summarize();
    end
endmodule

`default_nettype wire
